// ==== sim/cascade_stage.sv ====
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
// Upper stage of a cascade: the carry of the stage below is its
// count enable, so it steps at every unfrozen edge where that carry is high.
module cascade_stage (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Carry and freeze from the stage below
  input wire logic carry_in,
  input wire logic freeze_n,
  // Upper nibble
  output logic [3:0] upper_q
);
  // Carry is combinational below, so it is sampled at the shared edge
  always_ff @(posedge clk) begin
    if (rst) begin
      upper_q <= 4'h0;
    end else if (freeze_n && carry_in) begin
      upper_q <= upper_q + 4'h1;
    end
  end
endmodule

// ==== sim/tb_presettable_4bit_counter.sv ====
`timescale 1ns/1ps
`include "counter_defs.svh"
////////////////////////////////////////////////////////////////////////
module tb_presettable_4bit_counter
  import counter_pkg::*;
;
  logic clk = 1'b0; // 40 MHz
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic reset_n = 1'b1, load_n = 1'b1, enable_p = 1'b0, enable_t = 1'b0;
  logic [3:0] pre = 4'h0; // Preset pins, bit 0 least significant
  logic [3:0] cnt; // Count pins gathered
  logic tc;
  logic [3:0] upper;
  logic [3:0] cnt_a; // Count pins of the async build
  count_t exp_a; // Reference count, async build
  reg_addr_t awaddr = '0, araddr = '0;
  word_t wdata = '0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;
  logic chk_on = 1'b0; // Off while the model cannot track soft load
  count_t exp_q; // Reference count
  logic [3:0] hi_exp; // Reference upper stage
  logic [15:0] wraps_exp; // Reference rollover count
  logic [31:0] seed = 32'h5d40;
  logic [7:0] dir [8] = '{8'hbe, 8'hf0, 8'hd0, 8'he0, 8'hf0, 8'h3f,
                          8'hb5, 8'hb5};
  logic [3:0] pv;

  always #12.5 clk = ~clk;

  presettable_4bit_counter dut (
    .clk(clk), .rst(rst), .ce(ce), .reset_n(reset_n), .load_n(load_n),
    .enable_p(enable_p), .enable_t(enable_t),
    .preset_bit0(pre[0]), .preset_bit1(pre[1]),
    .preset_bit2(pre[2]), .preset_bit3(pre[3]),
    .count_bit0(cnt[0]), .count_bit1(cnt[1]),
    .count_bit2(cnt[2]), .count_bit3(cnt[3]), .terminal_count(tc),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready)
  );

  cascade_stage far (
    .clk(clk), .rst(rst), .carry_in(tc), .freeze_n(ce), .upper_q(upper)
  );

  // Second build with the immediate clear, bus left idle
  presettable_4bit_counter #(.ASYNC_RESET(1'b1)) dut_async (
    .clk(clk), .rst(rst), .ce(ce), .reset_n(reset_n), .load_n(load_n),
    .enable_p(enable_p), .enable_t(enable_t),
    .preset_bit0(pre[0]), .preset_bit1(pre[1]),
    .preset_bit2(pre[2]), .preset_bit3(pre[3]),
    .count_bit0(cnt_a[0]), .count_bit1(cnt_a[1]),
    .count_bit2(cnt_a[2]), .count_bit3(cnt_a[3]), .terminal_count(),
    .s_axi_awaddr(5'h00), .s_axi_awvalid(1'b0), .s_axi_awready(),
    .s_axi_wdata(32'h0), .s_axi_wstrb(4'h0), .s_axi_wvalid(1'b0),
    .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready(1'b0),
    .s_axi_araddr(5'h00), .s_axi_arvalid(1'b0), .s_axi_arready(),
    .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(1'b0)
  );

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  // Clear beats load, load beats count
  function automatic count_t next_cnt(input count_t c, input logic [3:0] k,
                                      input count_t p);
    if (!k[3]) return 4'h0;
    if (!k[2]) return p;
    if (k[1] && k[0]) return c + 4'h1;
    return c;
  endfunction

  // Reference model updates at the same edge as the design
  always @(posedge clk) begin
    if (rst) begin
      exp_q <= 4'h0;
      hi_exp <= 4'h0;
      wraps_exp <= 16'h0;
    end else if (ce) begin
      exp_q <= next_cnt(exp_q, {reset_n, load_n, enable_p, enable_t}, pre);
      if (enable_t && exp_q == 4'hf) hi_exp <= hi_exp + 4'h1;
      if (reset_n && load_n && enable_p && enable_t && exp_q == 4'hf) begin
        wraps_exp <= wraps_exp + 16'h1;
      end
    end
  end

  // Async build clears whenever reset_n is low, frozen or not
  always @(posedge clk) begin
    if (rst || !reset_n) begin
      exp_a <= 4'h0;
    end else if (ce) begin
      exp_a <= next_cnt(exp_a, {reset_n, load_n, enable_p, enable_t}, pre);
    end
  end

  task automatic check(input string nm, input word_t e, input word_t g);
    checks_done++;
    if (e !== g) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Mid-cycle comparison, well away from the launching edge
  always @(negedge clk) begin
    if (!rst) begin
      check("count_async", {28'h0, reset_n ? exp_a : 4'h0},
            {28'h0, cnt_a});
    end
    if (!rst && chk_on) begin
      check("count", {28'h0, exp_q}, {28'h0, cnt});
      check("carry", {31'h0, enable_t & (exp_q == 4'hf)},
            {31'h0, tc});
      check("upper", {28'h0, hi_exp}, {28'h0, upper});
    end
  end

  task automatic drive(input logic [7:0] w, input logic c);
    {reset_n, load_n, enable_p, enable_t} <= w[7:4];
    pre <= w[3:0];
    ce <= c;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Bus master: called right after a rising edge; holds each channel
  task automatic bus_wr(input reg_addr_t a, input word_t d,
                        input logic [1:0] er);
    logic aw_up, w_up;
    aw_up = 1'b1;
    w_up = 1'b1;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (aw_up || w_up) begin
      @(posedge clk);
      if (aw_up && awready) begin
        aw_up = 1'b0;
        awvalid <= 1'b0;
      end
      if (w_up && wready) begin
        w_up = 1'b0;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    check("bresp", {30'h0, er}, {30'h0, bresp});
  endtask

  task automatic bus_rd(input reg_addr_t a, input word_t ed,
                        input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    check("rdata", ed, rdata);
    check("rresp", {30'h0, er}, {30'h0, rresp});
  endtask

  task automatic give_verdict();
    if (mismatches == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Hang guard, well above the roughly 3070 cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 8000) begin
      mismatches++;
      give_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk_on <= 1'b1;
    // Corners: load, all ones, hold, kill carry, wrap, clear+load,
    // then a load held for two edges with the same preset
    foreach (dir[i]) begin
      drive(dir[i], 1'b1);
      @(posedge clk);
    end
    // Random control traffic, loads and clears kept fairly rare
    repeat (3000) begin
      seed = xs(seed);
      drive({seed[3:0] != 4'h0, seed[7:4] > 4'h1, seed[8] | seed[9],
             seed[10] | seed[11] | seed[12], seed[19:16]},
            seed[22:20] != 3'h0);
      @(posedge clk);
    end
    drive(8'h10, 1'b1);
    @(posedge clk);
    bus_rd(`REG_WRAPS, {16'h0, wraps_exp}, RESP_OKAY);
    drive(8'h50, 1'b1);
    @(posedge clk);
    drive(8'hd0, 1'b1);
    @(posedge clk);
    pv = {1'b0, seed[26:24]};
    bus_wr(`REG_PRESET, {28'h0, pv}, RESP_OKAY);
    bus_rd(`REG_PRESET, {28'h0, pv}, RESP_OKAY);
    chk_on <= 1'b0;
    bus_wr(`REG_CTRL, 32'h1, RESP_OKAY);
    repeat (3) @(posedge clk);
    bus_rd(`REG_STATUS, {28'h0, pv}, RESP_OKAY);
    bus_rd(`REG_CTRL, 32'h0, RESP_OKAY);
    bus_wr(`REG_STATUS, 32'hffffffff, RESP_OKAY);
    bus_rd(`REG_STATUS, {28'h0, pv}, RESP_OKAY);
    bus_wr(5'h10, 32'h1, RESP_SLVERR);
    bus_rd(5'h1c, 32'h0, RESP_SLVERR);
    bus_wr(`REG_WRAPS, 32'h1, RESP_OKAY);
    bus_rd(`REG_WRAPS, 32'h0, RESP_OKAY);
    // Pin clear brings design and model back in step
    drive(8'h50, 1'b1);
    @(posedge clk);
    drive(8'hd0, 1'b1);
    @(posedge clk);
    chk_on <= 1'b1;
    repeat (4) @(posedge clk);
    give_verdict();
  end
endmodule

// ==== src/axil_slave.sv ====
`timescale 1ns/1ps
`include "counter_defs.svh"

module axil_slave
  import counter_pkg::*;
(
  // Clock, reset and freeze
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Write address and data channels
  input wire logic [`AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // Write response channel
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read channels
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Register side
  output logic wr_fire,
  output reg_addr_t wr_addr,
  output word_t wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_err,
  input wire word_t rd_data,
  input wire logic rd_err
);

  ////////////////////////////////////////////////////////////////////////
  // Write path

  logic aw_full_q; // Address held, waiting for data
  logic w_full_q; // Data held, waiting for address
  logic aw_take;
  logic w_take;
  logic bvalid_d;

  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take = s_axi_wvalid & s_axi_wready;
  assign wr_fire = aw_full_q & w_full_q & ~s_axi_bvalid;
  assign bvalid_d = wr_fire | (s_axi_bvalid & ~s_axi_bready);

  // Holding flags and readies; no new write until the response is gone
  always_ff @(posedge clk) begin
    if (rst) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else if (ce) begin
      aw_full_q <= (aw_full_q | aw_take) & ~wr_fire;
      w_full_q <= (w_full_q | w_take) & ~wr_fire;
      s_axi_awready <= ~((aw_full_q | aw_take) & ~wr_fire) & ~bvalid_d;
      s_axi_wready <= ~((w_full_q | w_take) & ~wr_fire) & ~bvalid_d;
    end
  end

  // Payload capture
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_addr <= '0;
      wr_data <= '0;
      wr_strb <= '0;
    end else if (ce) begin
      if (aw_take) begin
        wr_addr <= s_axi_awaddr;
      end
      if (w_take) begin
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
    end
  end

  // Response held until the master takes it
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (ce) begin
      s_axi_bvalid <= bvalid_d;
      if (wr_fire) begin
        s_axi_bresp <= wr_err ? RESP_SLVERR : RESP_OKAY;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read path

  logic ar_take;
  logic rvalid_d;

  assign ar_take = s_axi_arvalid & s_axi_arready;
  assign rvalid_d = ar_take | (s_axi_rvalid & ~s_axi_rready);

  // Data sampled at the address edge; reads have no side effects
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (ce) begin
      s_axi_arready <= ~rvalid_d;
      s_axi_rvalid <= rvalid_d;
      if (ar_take) begin
        s_axi_rdata <= rd_data;
        s_axi_rresp <= rd_err ? RESP_SLVERR : RESP_OKAY;
      end
    end
  end

endmodule

// ==== src/count_core.sv ====
`timescale 1ns/1ps
`include "counter_defs.svh"

module count_core
  import counter_pkg::*;
#(
  parameter int WIDTH = `CNT_WIDTH,
  parameter bit ASYNC_RESET = 1'b0
) (
  // Clock, system reset and freeze
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Counter controls, all active as named
  input wire logic reset_n,
  input wire logic load_n,
  input wire logic enable_p,
  input wire logic enable_t,
  input wire logic [WIDTH-1:0] preset,
  // Count and carry
  output logic [WIDTH-1:0] count_q,
  output logic tc,
  output logic wrap
);

  ////////////////////////////////////////////////////////////////////////
  // Next count

  logic [WIDTH-1:0] count_d; // Value taken at the next edge
  logic count_en; // Both enables high and no load

  assign count_en = enable_p & enable_t & load_n; // R7 R11 R12

  // Reset beats load, load beats counting
  always_comb begin
    if (!reset_n) begin
      count_d = '0; // R4 R8
    end else if (!load_n) begin
      count_d = preset; // R5 R6
    end else if (count_en) begin
      count_d = WIDTH'(count_q + 1'b1); // R2 R16
    end else begin
      count_d = count_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Count register, one build option or the other

  generate
    if (ASYNC_RESET) begin : g_async
      // Clear acts at once; release must meet recovery before the edge
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          count_q <= '0; // R3
        end else if (rst) begin
          count_q <= '0;
        end else if (ce) begin
          count_q <= count_d; // R1
        end
      end
    end else begin : g_sync
      // Clear is just another edge action, glitch free for modulus use
      always_ff @(posedge clk) begin
        if (rst) begin
          count_q <= '0;
        end else if (ce) begin
          count_q <= count_d; // R1 R4
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Carry and wrap event

  // Left combinational so a cascade sees the carry in the same cycle
  assign tc = enable_t & (&count_q); // R9 R10 R11

  // One cycle pulse on the edge that rolls the count over
  assign wrap = ce & reset_n & count_en & (&count_q); // R16

endmodule

// ==== src/counter_defs.svh ====
`ifndef COUNTER_DEFS_SVH
`define COUNTER_DEFS_SVH

// Counter geometry
`define CNT_WIDTH 4

// Register bus geometry, byte addresses
`define AXI_ADDR_W 5
`define REG_CTRL 5'h00
`define REG_PRESET 5'h04
`define REG_STATUS 5'h08
`define REG_WRAPS 5'h0c

// Field positions
`define CTRL_SOFT_LOAD 0
`define STAT_TC 4
`define STAT_ASYNC 5

// Reset values and rollover count width
`define PRESET_RST 4'h0
`define WRAPS_W 16
`define WRAPS_RST 16'h0000

`endif

// ==== src/counter_pkg.sv ====
`include "counter_defs.svh"

package counter_pkg;

  // Count value as held by the counter
  typedef logic [`CNT_WIDTH-1:0] count_t;

  // Register bus address and data words
  typedef logic [`AXI_ADDR_W-1:0] reg_addr_t;
  typedef logic [31:0] word_t;

  // Bus response codes
  typedef enum logic [1:0] {
    RESP_OKAY = 2'b00,
    RESP_SLVERR = 2'b10
  } resp_t;

endpackage

// ==== src/presettable_4bit_counter.sv ====
`timescale 1ns/1ps
`include "counter_defs.svh"

// Summary of operation
// R1: State changes only on rising clock edge
// R2: Four bit count, plain binary increment
// R3: Low reset clears count at once, async
// R4: Sync option clears count at next edge
// R5: Low load copies preset into count
// R6: No increment while load is low
// R7: Count only with both enables and load high
// R8: Reset beats load, load beats count
// R9: Carry is trickle enable and all ones
// R10: Carry falls when count leaves all ones
// R11: Trickle enable low stops count, kills carry
// R12: Parallel enable stops count, not carry
// R13: Preset bit zero is count LSB
// R14: Count bit zero is the LSB
// R15: Carry may enable next cascaded stage
// R16: All ones plus one wraps to zero
module presettable_4bit_counter
  import counter_pkg::*;
#(
  parameter bit ASYNC_RESET = 1'b0
) (
  // Clock, system reset and freeze
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Counter controls from same-clock logic
  input wire logic reset_n,
  input wire logic load_n,
  input wire logic enable_p,
  input wire logic enable_t,
  // Preset data
  input wire logic preset_bit0,
  input wire logic preset_bit1,
  input wire logic preset_bit2,
  input wire logic preset_bit3,
  // Count and carry
  output logic count_bit0,
  output logic count_bit1,
  output logic count_bit2,
  output logic count_bit3,
  output logic terminal_count,
  // Register bus, write side
  input wire logic [`AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Register bus, read side
  input wire logic [`AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  count_t preset_pins; // Preset bits gathered, bit zero lowest
  count_t preset_eff; // Value the core loads
  count_t count_q; // Count held in the core
  logic load_n_eff; // Pin load merged with software load
  logic wrap; // Rollover pulse from the core
  logic soft_load_q; // One cycle software load
  count_t sw_preset_q; // Software preset value
  logic [`WRAPS_W-1:0] wraps_q; // Rollovers seen since last clear
  logic wraps_clr; // Software clear of the rollover count
  logic wr_fire; // Register write strobe
  reg_addr_t wr_addr;
  word_t wr_data;
  logic [3:0] wr_strb;
  logic wr_err;
  word_t rd_data;
  logic rd_err;

  ////////////////////////////////////////////////////////////////////////
  // Pin side

  // Bit zero of the preset is the least significant count bit
  assign preset_pins = {preset_bit3, preset_bit2,
                        preset_bit1, preset_bit0}; // R13

  // A pin load takes its data from the pins, a software load from the
  // register; a pin load in the same cycle wins
  assign load_n_eff = load_n & ~soft_load_q;
  assign preset_eff = load_n ? sw_preset_q : preset_pins; // R5

  // Count bits straight from the core register, bit zero lowest
  assign count_bit0 = count_q[0]; // R14
  assign count_bit1 = count_q[1];
  assign count_bit2 = count_q[2];
  assign count_bit3 = count_q[3];

  ////////////////////////////////////////////////////////////////////////
  // Counter core

  count_core #(
    .WIDTH(`CNT_WIDTH),
    .ASYNC_RESET(ASYNC_RESET)
  ) u_core (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .reset_n(reset_n),
    .load_n(load_n_eff),
    .enable_p(enable_p),
    .enable_t(enable_t),
    .preset(preset_eff),
    .count_q(count_q),
    .tc(terminal_count),
    .wrap(wrap)
  );

  ////////////////////////////////////////////////////////////////////////
  // Bus slave

  axil_slave u_bus (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_fire(wr_fire),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_err(wr_err),
    .rd_data(rd_data),
    .rd_err(rd_err)
  );

  ////////////////////////////////////////////////////////////////////////
  // Registers

  // Software load is a one-cycle pulse, so it cannot stall counting
  always_ff @(posedge clk) begin
    if (rst) begin
      soft_load_q <= 1'b0;
    end else if (ce) begin
      soft_load_q <= wr_fire && (wr_addr == `REG_CTRL) && wr_strb[0] &&
                     wr_data[`CTRL_SOFT_LOAD];
    end
  end

  // Software preset value, low byte lane only
  always_ff @(posedge clk) begin
    if (rst) begin
      sw_preset_q <= `PRESET_RST;
    end else if (ce && wr_fire && (wr_addr == `REG_PRESET) && wr_strb[0]) begin
      sw_preset_q <= wr_data[`CNT_WIDTH-1:0];
    end
  end

  // Any write to the rollover register with a byte strobe set clears it
  assign wraps_clr = wr_fire && (wr_addr == `REG_WRAPS) && (|wr_strb);

  // A rollover in the clearing cycle survives as a count of one
  always_ff @(posedge clk) begin
    if (rst) begin
      wraps_q <= `WRAPS_RST;
    end else if (ce) begin
      if (wrap) begin
        wraps_q <= wraps_clr ? `WRAPS_W'(1) : `WRAPS_W'(wraps_q + 1'b1);
      end else if (wraps_clr) begin
        wraps_q <= `WRAPS_RST;
      end
    end
  end

  // Writes outside the map are refused; status writes are ignored
  always_comb begin
    unique case (wr_addr)
      `REG_CTRL, `REG_PRESET, `REG_STATUS, `REG_WRAPS: begin
        wr_err = 1'b0;
      end
      default: begin
        wr_err = 1'b1;
      end
    endcase
  end

  // Read decode on the offered address; unused bits read zero
  always_comb begin
    rd_data = '0;
    rd_err = 1'b0;
    unique case (s_axi_araddr)
      `REG_CTRL: begin
        rd_data = '0;
      end
      `REG_PRESET: begin
        rd_data[`CNT_WIDTH-1:0] = sw_preset_q;
      end
      `REG_STATUS: begin
        rd_data[`CNT_WIDTH-1:0] = count_q;
        rd_data[`STAT_TC] = terminal_count;
        rd_data[`STAT_ASYNC] = ASYNC_RESET;
      end
      `REG_WRAPS: begin
        rd_data[`WRAPS_W-1:0] = wraps_q;
      end
      default: begin
        rd_err = 1'b1;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  logic inc_cond; // Conditions for an increment at this edge
  logic idle_cond; // Enabled edge with neither load nor increment

  assign inc_cond = ce && reset_n && load_n_eff && enable_p && enable_t;
  assign idle_cond = ce && reset_n && load_n_eff && !(enable_p && enable_t);

  chk_async_clear: assert property ( // R3
    (ASYNC_RESET && !reset_n) |-> (count_q == '0))
    else $error("count not clear under async reset");

  chk_sync_clear: assert property ( // R4
    (ce && !reset_n) |=> (count_q == '0))
    else $error("count not cleared after reset edge");

  chk_reset_wins: assert property ( // R8
    (ce && !reset_n && !load_n && enable_p && enable_t) |=> (count_q == '0))
    else $error("load or count beat reset");

  chk_load_value: assert property ( // R5
    (ce && reset_n && !load_n) |=> (count_q == $past(preset_pins) || !reset_n))
    else $error("load did not copy preset");

  chk_preset_order: assert property ( // R13
    (ce && reset_n && !load_n) |=>
      ((count_bit0 == $past(preset_bit0) && count_bit3 == $past(preset_bit3))
       || !reset_n))
    else $error("preset bit order wrong");

  chk_load_blocks: assert property ( // R6
    (ce && reset_n && !load_n && enable_p && enable_t) [*2] ##0
      $stable(preset_pins) |=> ($stable(count_q) || !reset_n))
    else $error("count moved during held load");

  chk_count_step: assert property ( // R2
    inc_cond |=> (count_q == count_t'($past(count_q) + 1'b1) || !reset_n))
    else $error("increment not by one");

  chk_hold_idle: assert property ( // R7
    idle_cond |=> ($stable(count_q) || !reset_n))
    else $error("count moved without both enables");

  chk_wrap_zero: assert property ( // R16
    (inc_cond && count_q == '1) |=> (count_q == '0 || !reset_n))
    else $error("no wrap from all ones");

  chk_lsb_toggle: assert property ( // R14
    inc_cond |=> (count_bit0 != $past(count_bit0) || !reset_n))
    else $error("bit zero did not toggle on count");

  chk_freeze_hold: assert property ( // R1
    (!ce && reset_n) |=> ($stable(count_q) || !reset_n))
    else $error("count moved while frozen");

  chk_carry_max: assert property ( // R9
    terminal_count |-> (count_q == '1 && enable_t))
    else $error("carry high off maximum");

  chk_carry_fall: assert property ( // R10
    ($past(count_q) == '1 && count_q != '1) |-> !terminal_count)
    else $error("carry stayed after leaving maximum");

  chk_trickle_gate: assert property ( // R11
    !enable_t |-> (!terminal_count ##1 ($stable(count_q) || !reset_n ||
      $past(!load_n_eff) || $past(!ce) == 1'b0 && $past(!reset_n))))
    else $error("trickle enable low did not gate");

  chk_parallel_free: assert property ( // R12
    (enable_t && !enable_p && count_q == '1) |-> terminal_count)
    else $error("parallel enable touched carry");

  chk_resp_hold: assert property (
    (s_axi_bvalid && !s_axi_bready) |=> (s_axi_bvalid && $stable(s_axi_bresp)))
    else $error("write response dropped early");

  cov_wrap: cover property (inc_cond && count_q == '1 ##1 count_q == '0);
  cov_load: cover property (ce && reset_n && !load_n);
  cov_carry: cover property (terminal_count ##1 !terminal_count);
  cov_write: cover property (s_axi_bvalid && s_axi_bready);
  cov_soft_load: cover property (soft_load_q && ce && load_n);

endmodule
